// *** hdl/fpg_pkg.sv ***
// Purpose: shared constants for the flash program/erase guard
// Assumes: 100 MHz core clock, 8-bit register port, byte-wide flash
// Notes: register offsets are local register-port addresses
package fpg_pkg;
	// register port geometry
	localparam int REG_AW = 8;
	localparam int REG_DW = 8;
	localparam logic [REG_AW-1:0] REG_PSC = 8'h00;
	localparam logic [REG_AW-1:0] REG_KEY = 8'h01;
	localparam logic [REG_AW-1:0] REG_RST_SOURCE = 8'h02;
	localparam logic [REG_AW-1:0] REG_SUPPLY = 8'h03;
	// field positions
	localparam int PSC_WE_BIT = 0;
	localparam int PSC_EE_BIT = 1;
	localparam int SUP_EN_BIT = 0;
	localparam int SUP_RST_BIT = 1;
	localparam int RST_SOURCE_ERR_BIT = 0;
	localparam logic [REG_DW-1:0] REG_RESET_VAL = 8'h00;
	// key codes and erased value
	localparam logic [7:0] KEY_FIRST = 8'ha5;
	localparam logic [7:0] KEY_SECOND = 8'hf1;
	localparam logic [7:0] FLASH_ERASED = 8'hff;
	// page geometry
	localparam int PAGE_BYTES = 512;
	localparam int PAGE_AW = 9;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_TIME_NS = 20000;
	localparam int ERASE_TIME_NS = 40000;
	localparam int WRITE_CYC = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 12;
	// key lock state as read back from the key register
	typedef enum logic [1:0] {
		FPG_KEY_LOCKED,
		FPG_KEY_HALF,
		FPG_KEY_OPEN,
		FPG_KEY_DEAD
	} fpg_key_t;
	typedef enum logic [1:0] {
		FPG_OP_IDLE,
		FPG_OP_WRITE,
		FPG_OP_ERASE
	} fpg_op_t;
endpackage : fpg_pkg

// *** hdl/fpg_flash_guard.sv ***
// Purpose: gate external data moves into program flash behind enables and a key
// Assumes: core strobes are on core_clk; por is power-on reset only
// Notes: flash array is modelled in place; erase sweeps one byte per cycle
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// [R1] programming only clears bits, erase sets
// [R2] hardware times every write and erase
// [R3] core stalled while operation runs
// [R4] write enable steers moves to flash
// [R5] move address and data used directly
// [R6] write enable stays until software clears
// [R7] monitor off means flash error reset
// [R8] software enables monitor reset promptly
// [R9] unlock only after first then second code
// [R10] wrong or reordered key locks until reset
// [R11] flash attempt before key locks until reset
// [R12] key relocks after each operation
// [R13] 512-byte pages, erase writes all ones
// [R14] erase enable turns move into page erase
// [R15] software disables interrupts, sets erase first
// [R16] software clears both enables after erase
// [R17] erase needs both enables set
// [R18] software repeats key per programmed byte
// [R19] flash error flag survives its reset
// [R20] write enable low sends moves to memory
module fpg_flash_guard import fpg_pkg::*; #(
	parameter int FLASH_AW = 11,
	parameter int XDM_AW = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [REG_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [REG_DW-1:0] reg_rdata,
	input wire logic xdm_wr,
	input wire logic [XDM_AW-1:0] xdm_addr,
	input wire logic [7:0] xdm_wdata,
	output logic xram_wr,
	output logic [XDM_AW-1:0] xram_addr,
	output logic [7:0] xram_wdata,
	output logic core_stall,
	input wire logic [FLASH_AW-1:0] code_addr,
	output logic [7:0] code_rdata,
	output logic flash_err_reset
);
	logic [7:0] flash_mem [0:(1<<FLASH_AW)-1];
	logic we_ff, ee_ff, mon_en_ff, mon_rst_ff;
	logic nxt_we, nxt_ee, nxt_mon_en, nxt_mon_rst;
	fpg_key_t key_ff, nxt_key;
	fpg_op_t op_ff, nxt_op;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [FLASH_AW-1:0] op_addr_ff, nxt_op_addr;
	logic [PAGE_AW:0] erase_idx_ff, nxt_erase_idx;
	logic [REG_DW-1:0] rdata_ff, nxt_rdata;
	logic xram_wr_ff, nxt_xram_wr;
	logic [XDM_AW-1:0] xram_addr_ff, nxt_xram_addr;
	logic [7:0] xram_wdata_ff, nxt_xram_wdata;
	logic err_ff, nxt_err;
	logic ferr_flag_ff, nxt_ferr_flag;
	logic [7:0] code_rdata_ff;
	logic flash_try, mon_ok, start_prog, start_erase, busy;
	logic [FLASH_AW-1:0] xdm_idx;

	assign busy = (op_ff != FPG_OP_IDLE);
	assign xdm_idx = xdm_addr[FLASH_AW-1:0];
	assign mon_ok = mon_en_ff & mon_rst_ff;
	// [R4] write enable steers
	assign flash_try = xdm_wr & we_ff & ~busy;
	// [R9] open key required
	assign start_prog = flash_try & mon_ok & (key_ff == FPG_KEY_OPEN) & ~ee_ff;
	// [R17] erase needs both
	assign start_erase = flash_try & mon_ok & (key_ff == FPG_KEY_OPEN) & ee_ff;

	always_comb begin
		nxt_we = we_ff;
		nxt_ee = ee_ff;
		nxt_mon_en = mon_en_ff;
		nxt_mon_rst = mon_rst_ff;
		nxt_key = key_ff;
		nxt_op = op_ff;
		nxt_cnt = cnt_ff;
		nxt_op_addr = op_addr_ff;
		nxt_erase_idx = erase_idx_ff;
		nxt_rdata = REG_RESET_VAL;
		nxt_xram_wr = 1'b0;
		nxt_xram_addr = xram_addr_ff;
		nxt_xram_wdata = xram_wdata_ff;
		nxt_err = 1'b0;
		if (reg_rd) begin
			case (reg_addr)
				REG_PSC: begin
					nxt_rdata[PSC_WE_BIT] = we_ff;
					nxt_rdata[PSC_EE_BIT] = ee_ff;
				end
				REG_KEY: nxt_rdata[1:0] = key_ff;
				REG_RST_SOURCE: nxt_rdata[RST_SOURCE_ERR_BIT] = ferr_flag_ff;
				REG_SUPPLY: begin
					nxt_rdata[SUP_EN_BIT] = mon_en_ff;
					nxt_rdata[SUP_RST_BIT] = mon_rst_ff;
				end
				default: nxt_rdata = REG_RESET_VAL;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				// [R6] cleared only by software
				REG_PSC: begin
					nxt_we = reg_wdata[PSC_WE_BIT];
					nxt_ee = reg_wdata[PSC_EE_BIT];
				end
				REG_SUPPLY: begin
					nxt_mon_en = reg_wdata[SUP_EN_BIT];
					nxt_mon_rst = reg_wdata[SUP_RST_BIT];
				end
				// [R9] [R10] key sequence check
				REG_KEY: begin
					case (key_ff)
						FPG_KEY_LOCKED: begin
							nxt_key = (reg_wdata == KEY_FIRST) ? FPG_KEY_HALF : FPG_KEY_DEAD;
						end
						FPG_KEY_HALF: begin
							nxt_key = (reg_wdata == KEY_SECOND) ? FPG_KEY_OPEN : FPG_KEY_DEAD;
						end
						default: nxt_key = FPG_KEY_DEAD;
					endcase
				end
				default: ;
			endcase
		end
		// [R20] plain moves to data memory
		if (xdm_wr & ~we_ff) begin
			nxt_xram_wr = 1'b1;
			nxt_xram_addr = xdm_addr;
			nxt_xram_wdata = xdm_wdata;
		end
		if (flash_try) begin
			if (!mon_ok) begin
				// [R7] flash error reset
				nxt_err = 1'b1;
			end else if (key_ff != FPG_KEY_OPEN) begin
				// [R11] early attempt kills key
				nxt_key = FPG_KEY_DEAD;
			end else begin
				// [R5] [R14] operands become target
				nxt_op_addr = xdm_idx;
				nxt_erase_idx = '0;
				nxt_op = ee_ff ? FPG_OP_ERASE : FPG_OP_WRITE;
				nxt_cnt = ee_ff ? CNT_W'(ERASE_CYC) : CNT_W'(WRITE_CYC);
			end
		end
		// [R2] internal operation timer
		case (op_ff)
			FPG_OP_IDLE: ;
			FPG_OP_WRITE, FPG_OP_ERASE: begin
				nxt_cnt = cnt_ff - CNT_W'(1);
				if (!erase_idx_ff[PAGE_AW] && op_ff == FPG_OP_ERASE) begin
					nxt_erase_idx = erase_idx_ff + (PAGE_AW+1)'(1);
				end
				if (cnt_ff == CNT_W'(1)) begin
					nxt_op = FPG_OP_IDLE;
					// [R12] relock after operation
					nxt_key = (key_ff == FPG_KEY_DEAD) ? FPG_KEY_DEAD : FPG_KEY_LOCKED;
				end
			end
			default: nxt_op = FPG_OP_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			we_ff <= 1'b0;
			ee_ff <= 1'b0;
			mon_en_ff <= 1'b0;
			mon_rst_ff <= 1'b0;
			key_ff <= FPG_KEY_LOCKED;
			op_ff <= FPG_OP_IDLE;
			cnt_ff <= '0;
			op_addr_ff <= '0;
			erase_idx_ff <= '0;
			rdata_ff <= REG_RESET_VAL;
			xram_wr_ff <= 1'b0;
			xram_addr_ff <= '0;
			xram_wdata_ff <= '0;
			err_ff <= 1'b0;
		end else begin
			we_ff <= nxt_we;
			ee_ff <= nxt_ee;
			mon_en_ff <= nxt_mon_en;
			mon_rst_ff <= nxt_mon_rst;
			key_ff <= nxt_key;
			op_ff <= nxt_op;
			cnt_ff <= nxt_cnt;
			op_addr_ff <= nxt_op_addr;
			erase_idx_ff <= nxt_erase_idx;
			rdata_ff <= nxt_rdata;
			xram_wr_ff <= nxt_xram_wr;
			xram_addr_ff <= nxt_xram_addr;
			xram_wdata_ff <= nxt_xram_wdata;
			err_ff <= nxt_err;
		end
	end

	// [R19] flag kept across the reset it causes
	always_comb begin
		nxt_ferr_flag = ferr_flag_ff | err_ff;
	end

	always_ff @(posedge core_clk or posedge por) begin
		if (por) begin
			ferr_flag_ff <= 1'b0;
		end else begin
			ferr_flag_ff <= nxt_ferr_flag;
		end
	end

	// flash array holds no reset; contents are nonvolatile
	always_ff @(posedge core_clk) begin
		if (start_prog) begin
			// [R1] programming can only clear bits
			flash_mem[xdm_idx] <= flash_mem[xdm_idx] & xdm_wdata;
		end else if (op_ff == FPG_OP_ERASE && !erase_idx_ff[PAGE_AW]) begin
			// [R13] whole page set to erased value
			flash_mem[{op_addr_ff[FLASH_AW-1:PAGE_AW], erase_idx_ff[PAGE_AW-1:0]}] <= FLASH_ERASED;
		end
		code_rdata_ff <= flash_mem[code_addr];
	end

	// [R3] stall core while busy
	assign core_stall = busy;
	assign reg_rdata = rdata_ff;
	assign xram_wr = xram_wr_ff;
	assign xram_addr = xram_addr_ff;
	assign xram_wdata = xram_wdata_ff;
	assign code_rdata = code_rdata_ff;
	assign flash_err_reset = err_ff;

	// helper for the timing checks: counts cycles of the running operation
	// so that long durations need no wide delay ranges
	logic [CNT_W-1:0] run_len_ff, nxt_run_len;

	always_comb begin
		nxt_run_len = run_len_ff;
		if (start_prog || start_erase) begin
			nxt_run_len = '0;
		end else if (busy) begin
			nxt_run_len = run_len_ff + CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			run_len_ff <= '0;
		end else begin
			run_len_ff <= nxt_run_len;
		end
	end

	a_prog_and_only: assert property (@(posedge core_clk) disable iff (rst) // [R1]
		start_prog |=> flash_mem[$past(xdm_idx)] == ($past(flash_mem[xdm_idx]) & $past(xdm_wdata)))
		else $error("program did not and data into flash byte");
	a_write_timed: assert property (@(posedge core_clk) disable iff (rst) // [R2]
		($fell(busy) && $past(op_ff) == FPG_OP_WRITE) |-> run_len_ff == CNT_W'(WRITE_CYC))
		else $error("flash write not timed");
	a_erase_stall: assert property (@(posedge core_clk) disable iff (rst) // [R3]
		($fell(core_stall) && $past(op_ff) == FPG_OP_ERASE) |-> run_len_ff == CNT_W'(ERASE_CYC))
		else $error("erase did not stall core for its duration");
	a_stall_starts: assert property (@(posedge core_clk) disable iff (rst) // [R3]
		(start_prog || start_erase) |=> core_stall)
		else $error("core not stalled when operation started");
	a_steer_data: assert property (@(posedge core_clk) disable iff (rst) // [R20]
		(xdm_wr && !we_ff) |=> (xram_wr && xram_addr == $past(xdm_addr) && !busy))
		else $error("plain move not sent to data memory");
	a_we_holds: assert property (@(posedge core_clk) disable iff (rst) // [R6]
		(we_ff && !(reg_wr && reg_addr == REG_PSC)) |=> we_ff)
		else $error("write enable dropped without software");
	a_monitor_error: assert property (@(posedge core_clk) disable iff (rst) // [R7]
		(flash_try && !mon_ok) |=> (flash_err_reset && !busy) ##1 ferr_flag_ff)
		else $error("flash error reset missing");
	a_wrong_key: assert property (@(posedge core_clk) disable iff (rst) // [R10]
		(reg_wr && reg_addr == REG_KEY && key_ff == FPG_KEY_LOCKED && reg_wdata != KEY_FIRST)
		|=> key_ff == FPG_KEY_DEAD)
		else $error("wrong key did not lock out");
	a_dead_sticky: assert property (@(posedge core_clk) disable iff (rst) // [R10]
		key_ff == FPG_KEY_DEAD |=> key_ff == FPG_KEY_DEAD && !busy)
		else $error("locked-out key recovered before reset");
	a_early_try: assert property (@(posedge core_clk) disable iff (rst) // [R11]
		(flash_try && mon_ok && key_ff != FPG_KEY_OPEN) |=> key_ff == FPG_KEY_DEAD)
		else $error("attempt before key did not lock out");
	a_relock_done: assert property (@(posedge core_clk) disable iff (rst) // [R12]
		$fell(busy) |-> key_ff == FPG_KEY_LOCKED)
		else $error("key not relocked after operation");
	a_erase_page: assert property (@(posedge core_clk) disable iff (rst) // [R13]
		$fell(busy) && $past(op_ff) == FPG_OP_ERASE
		|-> flash_mem[{op_addr_ff[FLASH_AW-1:PAGE_AW], {PAGE_AW{1'b0}}}] == FLASH_ERASED)
		else $error("erased page not all ones");
	a_erase_both: assert property (@(posedge core_clk) disable iff (rst) // [R17]
		(op_ff == FPG_OP_ERASE && !$past(busy)) |-> $past(we_ff) && $past(ee_ff))
		else $error("erase started without both enables");

	c_program: cover property (@(posedge core_clk) disable iff (rst) start_prog);
	c_erase: cover property (@(posedge core_clk) disable iff (rst) start_erase);
	c_error: cover property (@(posedge core_clk) disable iff (rst) flash_err_reset);
	c_lockout: cover property (@(posedge core_clk) disable iff (rst) key_ff == FPG_KEY_DEAD);
endmodule : fpg_flash_guard

// *** dv/fpg_core_model.sv ***
// Purpose: core-side model driving register writes and external data moves
// Assumes: every strobe changes by non-blocking assignment after the rising edge
// Notes: released address and data lines carry the inverse of their last value
`timescale 1ns/1ps
module fpg_core_model import fpg_pkg::*; (
	input wire logic core_clk,
	input wire logic core_stall,
	input wire logic [REG_DW-1:0] reg_rdata,
	output logic [REG_AW-1:0] reg_addr,
	output logic [REG_DW-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic xdm_wr,
	output logic [15:0] xdm_addr,
	output logic [7:0] xdm_wdata,
	input wire logic xram_wr,
	input wire logic flash_err_reset
);
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		xdm_wr = 1'b0;
		xdm_addr = '0;
		xdm_wdata = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : rd
	task automatic key_open(input int gap);
		wr(REG_KEY, KEY_FIRST);
		repeat (gap) @(posedge core_clk);
		wr(REG_KEY, KEY_SECOND);
	endtask : key_open
	task automatic mv(input logic [15:0] a, input logic [7:0] d, output logic xw,
		output logic fe, output logic [15:0] n);
		@(posedge core_clk);
		xdm_wr <= 1'b1;
		xdm_addr <= a;
		xdm_wdata <= d;
		@(posedge core_clk);
		xdm_wr <= 1'b0;
		xdm_addr <= ~a;
		xdm_wdata <= ~d;
		#1 xw = xram_wr;
		fe = flash_err_reset;
		n = 0;
		while (core_stall === 1'b1 && n < 16'hfff0) begin
			@(posedge core_clk);
			#1 n++;
		end
	endtask : mv
endmodule : fpg_core_model

// *** dv/tb_flash_program_erase_guard.sv ***
// Purpose: random and corner tests of flash steering, key, erase and error reset
// Assumes: default geometry, four 512-byte pages
// Notes: two pages are erased before any program result is read
`timescale 1ns/1ps
module tb_flash_program_erase_guard import fpg_pkg::*; ();
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b1;
	logic [10:0] code_addr = '0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, xdm_wdata, xram_wdata, code_rdata;
	logic [15:0] xdm_addr, xram_addr;
	logic reg_wr, reg_rd, xdm_wr, xram_wr, core_stall, flash_err_reset;
	int failures = 0;
	int num_checks = 0;
	always #5 core_clk = ~core_clk;
	fpg_flash_guard uut (.core_clk(core_clk), .rst(rst), .por(por), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.xdm_wr(xdm_wr), .xdm_addr(xdm_addr), .xdm_wdata(xdm_wdata), .xram_wr(xram_wr),
		.xram_addr(xram_addr), .xram_wdata(xram_wdata), .core_stall(core_stall),
		.code_addr(code_addr), .code_rdata(code_rdata), .flash_err_reset(flash_err_reset));
	fpg_core_model core (.core_clk(core_clk), .core_stall(core_stall), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.xdm_wr(xdm_wr), .xdm_addr(xdm_addr), .xdm_wdata(xdm_wdata), .xram_wr(xram_wr),
		.flash_err_reset(flash_err_reset));
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		if (failures == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic do_reset(input logic full);
		@(posedge core_clk);
		rst <= 1'b1;
		por <= full;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		por <= 1'b0;
	endtask : do_reset
	task automatic rdflash(input logic [15:0] a, output logic [7:0] d);
		@(posedge core_clk);
		code_addr <= a[10:0];
		@(posedge core_clk);
		#1 d = code_rdata;
	endtask : rdflash
	// expected byte after programming: bits can only clear
	function automatic logic [7:0] prog_exp(input logic [7:0] old_b, input logic [7:0] new_b);
		return old_b & new_b;
	endfunction : prog_exp
	// watchdog: four times the total operation time of the run
	initial begin
		#(4 * (2 * ERASE_CYC + 2 * WRITE_CYC) * CLK_PERIOD_NS);
		failures++;
		stop_test();
	end
	initial begin
		logic [7:0] d, d2, e, v;
		logic xw, fe;
		logic [15:0] n, a;
		logic [15:0] bnd [4] = '{16'd0, 16'd511, 16'd512, 16'd1023};
		void'($urandom(62922));
		do_reset(1'b1);
		for (int i = 0; i < 5; i++) begin
			core.rd(8'(i), v);
			check("reset_value", v, 16'(REG_RESET_VAL));
		end
		for (int i = 0; i < 2; i++) begin
			core.wr(REG_PSC, 8'(i * 2));
			a = 16'($urandom);
			d = 8'($urandom);
			core.mv(a, d, xw, fe, n);
			check("xram_wr", xw, 1);
			check("xram_addr", xram_addr, a);
			check("xram_data", xram_wdata, d);
			check("xram_stall", n, 0);
		end
		core.wr(REG_SUPPLY, 8'h03);
		for (int i = 0; i < 2; i++) begin
			core.wr(REG_PSC, 8'h02);
			core.wr(REG_PSC, 8'h03);
			core.key_open($urandom % 40);
			a = 16'(i * PAGE_BYTES + $urandom % PAGE_BYTES);
			core.mv(a, 8'($urandom), xw, fe, n);
			check("erase_cycles", n, 16'(ERASE_CYC));
			core.rd(REG_KEY, v);
			check("erase_relock", v, FPG_KEY_LOCKED);
			core.wr(REG_PSC, 8'h00);
		end
		foreach (bnd[j]) begin
			rdflash(bnd[j], v);
			check("erased_byte", v, FLASH_ERASED);
		end
		a = 16'($urandom % (2 * PAGE_BYTES));
		// bit 0 kept set so a later stray program of zero would show
		d = 8'($urandom) | 8'h01;
		d2 = 8'($urandom) | 8'h01;
		e = prog_exp(prog_exp(FLASH_ERASED, d), d2);
		core.wr(REG_PSC, 8'h01);
		core.key_open(0);
		core.mv(a, d, xw, fe, n);
		check("write_cycles", n, 16'(WRITE_CYC));
		check("no_xram", xw, 0);
		core.rd(REG_KEY, v);
		check("key_relock", v, FPG_KEY_LOCKED);
		core.key_open(3);
		core.mv(a, d2, xw, fe, n);
		check("write2_cycles", n, 16'(WRITE_CYC));
		core.rd(REG_PSC, v);
		check("we_kept", v, 16'h01);
		rdflash(a, v);
		check("flash_and", v, e);
		for (int i = 0; i < 3; i++) begin
			do_reset(1'b0);
			core.wr(REG_SUPPLY, 8'h03);
			core.wr(REG_PSC, 8'h01);
			if (i == 0) begin
				core.wr(REG_KEY, KEY_FIRST);
				core.rd(REG_KEY, v);
				check("key_half", v, FPG_KEY_HALF);
				d = 8'($urandom);
				core.wr(REG_KEY, (d == KEY_SECOND) ? 8'h00 : d);
			end else if (i == 1) begin
				core.wr(REG_KEY, KEY_SECOND);
			end else begin
				core.mv(a, 8'h00, xw, fe, n);
			end
			core.rd(REG_KEY, v);
			check("key_dead", v, FPG_KEY_DEAD);
			core.key_open(1);
			core.mv(a, 8'h00, xw, fe, n);
			check("dead_stall", n, 0);
			rdflash(a, v);
			check("dead_flash", v, e);
		end
		for (int i = 0; i < 3; i++) begin
			do_reset(1'b0);
			core.wr(REG_SUPPLY, 8'(i));
			core.wr(REG_PSC, 8'h01);
			core.key_open(2);
			core.mv(a, 8'h00, xw, fe, n);
			check("flash_err_reset", fe, 1);
			check("err_stall", n, 0);
			do_reset(1'b0);
			core.rd(REG_RST_SOURCE, v);
			check("ferr_flag", v, 16'(1 << RST_SOURCE_ERR_BIT));
			rdflash(a, v);
			check("err_flash", v, e);
		end
		stop_test();
	end
endmodule : tb_flash_program_erase_guard
